// >>> hdl/twssp_host.sv
// Host controller that drives the sensor's serial clock, instruction line
// and master clock, and reads words back from the sensor output line.
// Assumes the sensor output line is asynchronous to clock_in.
`include "twssp_map.svh"

module twssp_host
	import twssp_pkg::*;
#(
	parameter logic [3:0]  SETUP_PRESSURE = `TWSSP_SETUP_PRESSURE,
	parameter logic [3:0]  SETUP_TEMP     = `TWSSP_SETUP_TEMP,
	parameter logic [3:0]  SETUP_CAL1     = `TWSSP_SETUP_CAL1,
	parameter logic [3:0]  SETUP_CAL2     = `TWSSP_SETUP_CAL2,
	parameter logic [3:0]  SETUP_CAL3     = `TWSSP_SETUP_CAL3,
	parameter logic [3:0]  SETUP_CAL4     = `TWSSP_SETUP_CAL4,
	parameter logic [20:0] RESET_PATTERN  = `TWSSP_RESET_PATTERN
) (
	input  wire logic       clock_in,
	input  wire logic       rstn_in,
	input  wire twssp_cmd_t cmd_in,
	output logic            cmd_ready_out,
	output twssp_rsp_t      rsp_out,
	output logic            conv_busy_out,
	output logic            sclk_out,
	output logic            din_out,
	output logic            mclk_out,
	input  wire logic       dout_in
);
	// ****************************************
	// Types and helpers
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_SHIFT = 3'h1,
		ST_EXTRA = 3'h2,
		ST_WAIT  = 3'h3,
		ST_READ  = 3'h4
	} twssp_state_t;

	localparam logic [7:0]  HALF_CYC = 8'(`TWSSP_SCLK_HALF_CYC);
	localparam logic [12:0] MCLK_HALF = 13'(`TWSSP_MCLK_HALF_CYC);

	function automatic logic [3:0] twssp_setup(input twssp_op_t op);
		unique case (op)
			TWSSP_OP_PRESSURE: twssp_setup = SETUP_PRESSURE;
			TWSSP_OP_TEMP:     twssp_setup = SETUP_TEMP;
			TWSSP_OP_CAL1:     twssp_setup = SETUP_CAL1;
			TWSSP_OP_CAL2:     twssp_setup = SETUP_CAL2;
			TWSSP_OP_CAL3:     twssp_setup = SETUP_CAL3;
			TWSSP_OP_CAL4:     twssp_setup = SETUP_CAL4;
			default:           twssp_setup = 4'h0;
		endcase
	endfunction : twssp_setup

	function automatic logic twssp_is_conv(input twssp_op_t op);
		twssp_is_conv = (op == TWSSP_OP_PRESSURE) || (op == TWSSP_OP_TEMP);
	endfunction : twssp_is_conv

	// ****************************************
	// Master clock and input synchroniser
	// ****************************************
	logic [12:0] mclk_cnt;
	logic [12:0] next_mclk_cnt;
	logic        mclk;
	logic        next_mclk;
	logic        dout_meta;
	logic        dout_sync;
	logic        dout_prev;

	always_comb begin
		next_mclk_cnt = mclk_cnt + 13'h1;
		next_mclk     = mclk;
		if (mclk_cnt >= MCLK_HALF - 13'h1) begin
			next_mclk_cnt = 13'h0;
			next_mclk     = ~mclk;
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mclk_cnt  <= 13'h0;
			mclk      <= 1'b0;
			dout_meta <= 1'b0;
			dout_sync <= 1'b0;
			dout_prev <= 1'b0;
		end else begin
			mclk_cnt  <= next_mclk_cnt;
			mclk      <= next_mclk;
			dout_meta <= dout_in;
			dout_sync <= dout_meta;
			dout_prev <= dout_sync;
		end
	end

	// ****************************************
	// Protocol sequencer
	// ****************************************
	twssp_state_t state;
	twssp_state_t next_state;
	twssp_op_t    op;
	twssp_op_t    next_op;
	logic [20:0]  shreg;
	logic [20:0]  next_shreg;
	logic [4:0]   bits;
	logic [4:0]   next_bits;
	logic [7:0]   tick;
	logic [7:0]   next_tick;
	logic         sclk;
	logic         next_sclk;
	logic         din;
	logic         next_din;
	logic [15:0]  word;
	logic [15:0]  next_word;
	twssp_rsp_t   rsp;
	twssp_rsp_t   next_rsp;
	logic         busy;
	logic         next_busy;
	logic         rdy;
	logic         next_rdy;
	logic         half_done;
	logic         fall;

	assign half_done = (tick == HALF_CYC - 8'h1);
	assign fall      = half_done && sclk;

	always_comb begin
		next_state = state;
		next_op    = op;
		next_shreg = shreg;
		next_bits  = bits;
		next_tick  = tick;
		next_sclk  = sclk;
		next_din   = din;
		next_word  = word;
		next_rsp   = rsp;
		next_rsp.valid = 1'b0;
		next_busy  = busy;
		next_rdy   = 1'b0;
		unique case (state)
			ST_IDLE: begin
				next_sclk = 1'b0;
				next_tick = 8'h0;
				if (cmd_in.valid && rdy) begin
					next_op = cmd_in.op;
					if (cmd_in.op == TWSSP_OP_RESET) begin
						next_shreg = RESET_PATTERN;
						next_bits  = 5'(`TWSSP_RESET_BITS);
					end else begin
						// Start, setup, stop, left aligned for MSB-first shifting
						next_shreg = {3'b111, twssp_setup(cmd_in.op), 3'b000, 11'h0};
						next_bits  = 5'(`TWSSP_INSTR_BITS);
					end
					next_din   = next_shreg[20];
					next_shreg = next_shreg << 1;
					next_busy  = twssp_is_conv(cmd_in.op);
					next_state = ST_SHIFT;
				end else begin
					next_rdy = 1'b1;
				end
			end
			ST_SHIFT, ST_EXTRA, ST_READ: begin
				next_tick = half_done ? 8'h0 : tick + 8'h1;
				if (half_done) begin
					next_sclk = ~sclk;
				end
				if (fall) begin
					next_bits = bits - 5'h1;
					if (state == ST_READ && bits != 5'(`TWSSP_READ_CLKS)) begin
						// First readout clock carries no data bit
						next_word = {word[14:0], dout_sync};
					end
					if (state == ST_SHIFT) begin
						next_din   = shreg[20];
						next_shreg = shreg << 1;
					end
					if (bits == 5'h1) begin
						next_din = 1'b0;
						if (state == ST_SHIFT && op == TWSSP_OP_RESET) begin
							// Output activity during reset is ignored
							next_state = ST_IDLE;
							next_rdy   = 1'b1;
						end else if (state == ST_SHIFT && twssp_is_conv(op)) begin
							next_bits  = 5'(`TWSSP_ACK_EXTRA_CLKS);
							next_state = ST_EXTRA;
						end else if (state == ST_EXTRA) begin
							next_state = ST_WAIT;
						end else if (state == ST_SHIFT) begin
							next_bits  = 5'(`TWSSP_READ_CLKS);
							next_state = ST_READ;
						end else begin
							next_rsp.valid = 1'b1;
							next_rsp.op    = op;
							next_rsp.data  = {word[14:0], dout_sync};
							next_busy      = 1'b0;
							next_state     = ST_IDLE;
						end
					end
				end
			end
			ST_WAIT: begin
				next_sclk = 1'b0;
				next_tick = 8'h0;
				if (dout_prev && !dout_sync) begin
					next_bits  = 5'(`TWSSP_READ_CLKS);
					next_state = ST_READ;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= ST_IDLE;
			op    <= TWSSP_OP_RESET;
			shreg <= 21'h0;
			bits  <= 5'h0;
			tick  <= 8'h0;
			sclk  <= 1'b0;
			din   <= 1'b0;
			word  <= 16'h0;
			rsp   <= '0;
			busy  <= 1'b0;
			rdy   <= 1'b0;
		end else begin
			state <= next_state;
			op    <= next_op;
			shreg <= next_shreg;
			bits  <= next_bits;
			tick  <= next_tick;
			sclk  <= next_sclk;
			din   <= next_din;
			word  <= next_word;
			rsp   <= next_rsp;
			busy  <= next_busy;
			rdy   <= next_rdy;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// All straight from flip-flops; the sensor samples on our rising edge
	assign sclk_out      = sclk;
	assign din_out       = din;
	assign mclk_out      = mclk;
	assign rsp_out       = rsp;
	assign conv_busy_out = busy;
	assign cmd_ready_out = rdy;
endmodule : twssp_host

// >>> hdl/twssp_map.svh
// Constants for the three-wire sensor port host controller.
// Assumes inclusion by its bare name from the package and the controller.
`ifndef TWSSP_MAP_SVH
`define TWSSP_MAP_SVH
// ****************************************
// Serial clock timing
// ****************************************
`define TWSSP_CLK_PERIOD_NS   4
`define TWSSP_SCLK_HALF_NS    400
`define TWSSP_SCLK_HALF_CYC   ((`TWSSP_SCLK_HALF_NS + `TWSSP_CLK_PERIOD_NS - 1) / `TWSSP_CLK_PERIOD_NS)
// ****************************************
// Master clock divider (32.768 kHz from 250 MHz, half period rounded down)
// ****************************************
`define TWSSP_MCLK_HZ         32768
`define TWSSP_CLK_HZ          250000000
`define TWSSP_MCLK_HALF_CYC   (`TWSSP_CLK_HZ / (2 * `TWSSP_MCLK_HZ))
// ****************************************
// Frame layout
// ****************************************
`define TWSSP_START_BITS      3
`define TWSSP_SETUP_BITS      4
`define TWSSP_STOP_BITS       3
`define TWSSP_INSTR_BITS      10
`define TWSSP_ACK_EXTRA_CLKS  2
`define TWSSP_READ_CLKS       17
`define TWSSP_WORD_BITS       16
`define TWSSP_RESET_BITS      21
// ****************************************
// Default codes (arbitrary, set per sensor)
// ****************************************
`define TWSSP_SETUP_PRESSURE  4'hf
`define TWSSP_SETUP_TEMP      4'h9
`define TWSSP_SETUP_CAL1      4'h5
`define TWSSP_SETUP_CAL2      4'h6
`define TWSSP_SETUP_CAL3      4'h9
`define TWSSP_SETUP_CAL4      4'ha
`define TWSSP_RESET_PATTERN   21'h155540
`endif

// >>> hdl/twssp_pkg.sv
// Types for the three-wire sensor port host controller.
// Assumes twssp_map.svh on the include path.
`include "twssp_map.svh"
package twssp_pkg;
	typedef enum logic [2:0] {
		TWSSP_OP_PRESSURE = 3'h0,
		TWSSP_OP_TEMP     = 3'h1,
		TWSSP_OP_CAL1     = 3'h2,
		TWSSP_OP_CAL2     = 3'h3,
		TWSSP_OP_CAL3     = 3'h4,
		TWSSP_OP_CAL4     = 3'h5,
		TWSSP_OP_RESET    = 3'h6
	} twssp_op_t;
	typedef struct packed {
		logic      valid;
		twssp_op_t op;
	} twssp_cmd_t;
	typedef struct packed {
		logic        valid;
		twssp_op_t   op;
		logic [15:0] data;
	} twssp_rsp_t;
endpackage : twssp_pkg

// >>> bench/twssp_host_properties.sv
// Checker for the sensor port host controller.
// Assumes it is bound onto twssp_host and sees only its ports.
module twssp_host_properties
	import twssp_pkg::*;
(
	input  wire logic       clock_in,
	input  wire logic       rstn_in,
	input  wire twssp_cmd_t cmd_in,
	input  wire logic       cmd_ready_out,
	input  wire twssp_rsp_t rsp_out,
	input  wire logic       conv_busy_out,
	input  wire logic       sclk_out,
	input  wire logic       din_out,
	input  wire logic       mclk_out,
	input  wire logic       dout_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        s_q;
	logic        m_q;
	logic        m_seen;
	logic [7:0]  hcnt;
	logic [11:0] mcnt;
	// Counters restart on each edge of the watched clock line
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_q    <= 1'b0;
			m_q    <= 1'b0;
			m_seen <= 1'b0;
			hcnt   <= 8'h0;
			mcnt   <= 12'h0;
		end else begin
			s_q    <= sclk_out;
			m_q    <= mclk_out;
			m_seen <= m_seen | (mclk_out != m_q);
			hcnt   <= (sclk_out != s_q) ? 8'h0 : hcnt + 8'h1;
			mcnt   <= (mclk_out != m_q) ? 12'h0 : mcnt + 12'h1;
		end
	end
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	a_din_at_fall: assert property (
		$changed(din_out) |-> $fell(sclk_out) || $fell(cmd_ready_out)) else $error("din off fall");
	a_sclk_high: assert property (
		$fell(sclk_out) |-> hcnt == 8'h63) else $error("sclk high time");
	a_idle_low: assert property (
		cmd_ready_out |-> !sclk_out) else $error("sclk runs while idle");
	a_ready_drop: assert property (
		cmd_in.valid && cmd_ready_out |=> !cmd_ready_out) else $error("ready stays");
	a_busy_set: assert property (
		cmd_in.valid && cmd_ready_out && cmd_in.op inside {TWSSP_OP_PRESSURE, TWSSP_OP_TEMP}
		|=> conv_busy_out) else $error("busy not set");
	a_rsp_pulse: assert property (
		rsp_out.valid |-> !sclk_out ##1 !rsp_out.valid) else $error("rsp pulse");
	a_rsp_ready: assert property (
		rsp_out.valid |-> ##[1:2] cmd_ready_out) else $error("ready late");
	a_mclk_half: assert property (
		m_seen && mclk_out != m_q |-> mcnt == 12'hee5) else $error("mclk half period");
endmodule : twssp_host_properties
bind twssp_host twssp_host_properties i_twssp_host_properties (.clock_in(clock_in),
	.rstn_in(rstn_in), .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out), .rsp_out(rsp_out),
	.conv_busy_out(conv_busy_out), .sclk_out(sclk_out), .din_out(din_out),
	.mclk_out(mclk_out), .dout_in(dout_in));

// >>> bench/twssp_sensor_model.sv
// Behavioural sensor on the far side of the serial port.
// Assumes a host that paces sclk_in and shifts din_in at its falls.
module twssp_sensor_model #(
	parameter logic [3:0]  SP     = 4'hf,
	parameter logic [3:0]  ST     = 4'h9,
	parameter logic [3:0]  SC [4] = '{4'h5, 4'h6, 4'h3, 4'ha},
	parameter logic [20:0] RP     = 21'h155540,
	parameter logic [15:0] WP     = 16'h8a3c,
	parameter logic [15:0] WT     = 16'h51e7,
	parameter logic [15:0] WC [4] = '{16'h1234, 16'hfedc, 16'h0ff0, 16'ha55a}
) (
	input  wire logic sclk_in,
	input  wire logic din_in,
	output logic      dout_out,
	output int        resets_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [20:0] hist = '0;
	logic [15:0] word;
	int          st = 0;
	int          k;
	initial dout_out = 1'b0;
	initial resets_out = 0;
	always @(posedge sclk_in) begin
		hist = {hist[19:0], din_in};
		if (hist == RP) begin
			st = 0;
			resets_out++;
		end else if (st == 0) begin
			// Idle line wanders so a host must not trust it
			dout_out = ~dout_out;
			if (hist[9:0] == {3'b111, SP, 3'b000} || hist[9:0] == {3'b111, ST, 3'b000}) begin
				word = (hist[6:3] == SP) ? WP : WT;
				dout_out = 1'b1;
				st = 1;
				k = 0;
			end
			for (int i = 0; i < 4; i++) begin
				if (hist[9:0] == {3'b111, SC[i], 3'b000}) begin
					word = WC[i];
					st = 3;
					k = 0;
				end
			end
		end else if (st == 1) begin
			k++;
			if (k == 2) st = 2;
		end else if (st == 3) begin
			k++;
			dout_out = (k == 1) ? 1'b0 : word[17 - k];
			if (k == 17) st = 0;
		end
	end
	always @(negedge sclk_in) if (st == 2) begin
		#2000;
		dout_out = 1'b0;
		st = 3;
		k = 0;
	end
endmodule : twssp_sensor_model

// >>> bench/three_wire_sensor_serial_port_test.sv
// Self-checking bench for the sensor port host controller.
// Assumes the behavioural sensor model and the bound checker.
module three_wire_sensor_serial_port_test
	import twssp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] WC [4] = '{16'h1234, 16'hfedc, 16'h0ff0, 16'ha55a};
	logic       clock_in = 1'b0;
	logic       rstn_in = 1'b0;
	twssp_cmd_t cmd = '0;
	twssp_rsp_t rsp;
	logic       ready, busy, sclk, din, mclk, dout;
	int         fails = 0, n_tests = 0, cyc = 0, resets;
	always #2 clock_in = ~clock_in;
	// Cal word 3 moved off the temperature code so the two can be told apart
	twssp_host #(.SETUP_CAL3(4'h3)) i_twssp_host (.clock_in(clock_in), .rstn_in(rstn_in),
		.cmd_in(cmd), .cmd_ready_out(ready), .rsp_out(rsp), .conv_busy_out(busy),
		.sclk_out(sclk), .din_out(din), .mclk_out(mclk), .dout_in(dout));
	twssp_sensor_model i_twssp_sensor_model (.sclk_in(sclk), .din_in(din), .dout_out(dout),
		.resets_out(resets));
	task check(string what, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task finish_test();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	task wait_ready();
		int i;
		i = 0;
		while (ready !== 1'b1 && i < 10000) begin
			@(negedge clock_in);
			i++;
		end
		check("ready", ready, 1);
	endtask : wait_ready
	task send(twssp_op_t op);
		wait_ready();
		cmd = '{1'b1, op};
		@(negedge clock_in);
		cmd.valid = 1'b0;
	endtask : send
	task get(twssp_op_t op, logic [15:0] exp);
		int i;
		i = 0;
		while (rsp.valid !== 1'b1 && i < 9000) begin
			@(negedge clock_in);
			i++;
		end
		// A timed-out wait must not pass on a stale word
		check("rsp valid", rsp.valid, 1);
		check("rsp op", rsp.op, op);
		check("rsp data", rsp.data, exp);
	endtask : get
	// ****
	// Scenarios
	// ****
	task t_cal();
		for (int i = 0; i < 4; i++) begin
			send(twssp_op_t'(TWSSP_OP_CAL1 + i));
			get(twssp_op_t'(TWSSP_OP_CAL1 + i), WC[i]);
		end
		$display("calibration reads done");
	endtask : t_cal
	task t_conv();
		send(TWSSP_OP_PRESSURE);
		check("busy", busy, 1);
		get(TWSSP_OP_PRESSURE, 16'h8a3c);
		send(TWSSP_OP_TEMP);
		get(TWSSP_OP_TEMP, 16'h51e7);
		$display("conversions done");
	endtask : t_conv
	task t_refuse();
		send(TWSSP_OP_PRESSURE);
		repeat (50) @(negedge clock_in);
		// Command offered while busy must leave no trace
		cmd = '{1'b1, TWSSP_OP_CAL1};
		repeat (20) @(negedge clock_in);
		cmd.valid = 1'b0;
		get(TWSSP_OP_PRESSURE, 16'h8a3c);
		repeat (4) @(negedge clock_in);
		check("idle after", {ready, sclk}, 2'b10);
		$display("refusal done");
	endtask : t_refuse
	task t_reset();
		int r;
		r = resets;
		send(TWSSP_OP_RESET);
		wait_ready();
		check("resets", resets, r + 1);
		send(TWSSP_OP_TEMP);
		get(TWSSP_OP_TEMP, 16'h51e7);
		$display("reset done");
	endtask : t_reset
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 80000) begin
			fails++;
			finish_test();
		end
	end
	initial begin
		repeat (6) @(negedge clock_in);
		rstn_in = 1'b1;
		repeat (2) @(negedge clock_in);
		t_cal();
		t_conv();
		t_refuse();
		t_reset();
		finish_test();
	end
endmodule : three_wire_sensor_serial_port_test
